// ==== common/vic_arb_if.sv ====
// Purpose: Carries requests and priorities to the arbiter and the winner back.
// Assumes: Combinational path within one clock domain.
// Notes: Priorities are packed, line i at bits i*PW.
`timescale 1ns/1ps
interface vic_arb_if #(
  parameter int N = 32,
  parameter int PW = 3,
  parameter int LW = 5
);
  logic [N-1:0] req;           // Enabled, pending and unmasked lines
  logic [N*PW-1:0] prio;       // Packed priorities
  logic win_valid;             // Some line requests
  logic [LW-1:0] win_line;     // Winning line
  modport core (output req, output prio, input win_valid, input win_line);
  modport arb (input req, input prio, output win_valid, output win_line);
endinterface

// ==== common/vic_pkg.sv ====
// Purpose: Shared constants for the vectored interrupt controller.
// Assumes: 32-bit AXI4-Lite register bus, one clock, one reset.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package vic_pkg;
  // ********
  // Sizes
  // ********
  localparam int VIC_LINES = 32;            // User interrupt lines
  localparam int VIC_LINE_W = 5;            // Line number width
  localparam int VIC_SYS = 16;              // System exception vectors
  localparam int VIC_SYS_W = 4;             // Exception number width
  localparam int VIC_PRIO_W = 3;            // Priority width
  localparam int VIC_VEC_W = 32;            // Vector address width
  localparam int VIC_AW = 8;                // Bus address width
  localparam int VIC_DW = 32;               // Bus data width

  // ********
  // Register offsets
  // ********
  localparam logic [VIC_AW-1:0] OFF_CTRL = 8'h00;     // Global mask
  localparam logic [VIC_AW-1:0] OFF_EN_SET = 8'h04;   // Enable word, write sets
  localparam logic [VIC_AW-1:0] OFF_EN_SAVE = 8'h08;  // Read enables, then clear all
  localparam logic [VIC_AW-1:0] OFF_LINE_CMD = 8'h0C; // Per-line command
  localparam logic [VIC_AW-1:0] OFF_LINE_SEL = 8'h10; // Selected line
  localparam logic [VIC_AW-1:0] OFF_LINE_STAT = 8'h14;// Selected line state
  localparam logic [VIC_AW-1:0] OFF_LINE_PRIO = 8'h18;// Selected line priority
  localparam logic [VIC_AW-1:0] OFF_LINE_VEC = 8'h1C; // Selected line vector
  localparam logic [VIC_AW-1:0] OFF_SYS_SEL = 8'h20;  // Selected exception
  localparam logic [VIC_AW-1:0] OFF_SYS_VEC = 8'h24;  // Selected exception vector
  localparam logic [VIC_AW-1:0] OFF_PEND = 8'h28;     // Pending word
  localparam logic [VIC_AW-1:0] OFF_ACTIVE = 8'h2C;   // Presented request

  // ********
  // Field positions and codes
  // ********
  localparam int CTRL_GIE_BIT = 0;          // Global enable flag
  localparam int CMD_LINE_LSB = 0;          // Line number in command
  localparam int CMD_OP_LSB = 8;            // Operation in command
  localparam int STAT_EN_BIT = 0;           // Enable in line state
  localparam int STAT_PEND_BIT = 1;         // Pending in line state
  localparam int STAT_PRIO_LSB = 4;         // Priority in line state
  localparam int ACT_VALID_BIT = 31;        // Request shown flag
  typedef enum logic [1:0] {
    VIC_OP_ENABLE,
    VIC_OP_DISABLE,
    VIC_OP_SET_PEND,
    VIC_OP_CLR_PEND
  } vic_op_e;

  // ********
  // Reset values and responses
  // ********
  localparam logic [VIC_LINES-1:0] EN_RST = 32'h0000_0000;
  localparam logic [VIC_PRIO_W-1:0] PRIO_RST = 3'h7;
  localparam logic [VIC_VEC_W-1:0] VEC_RST = 32'h0000_0000;
  localparam logic GIE_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for the vectored interrupt controller.
// Assumes: AXI4-Lite master tasks, core model on the request side.
// Notes: Random values from a fixed seed; expectations kept in bench arrays.
`timescale 1ns/1ps
module tb;
  import vic_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, takes, seen;
  logic [31:0] wdata, rdata, irq_src, irq_vector, t_vec, en_m, pend_m, m;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic irq_req, irq_ack;
  logic [4:0] irq_line, t_line;
  logic [2:0] delay;
  logic [31:0] vec_m [32];  // Expected line vectors
  logic [31:0] sv [16];  // Expected exception vectors
  logic [2:0] prio_m [32];  // Expected priorities
  int fails, compares, seed, l;
  // ********
  // Clock, design and core
  // ********
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  vic_top dut (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready), .irq_src(irq_src),
    .irq_req(irq_req), .irq_line(irq_line), .irq_vector(irq_vector), .irq_ack(irq_ack));
  vic_core_model core (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req), .irq_line(irq_line),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .delay(delay), .takes(takes), .taken_line(t_line),
    .taken_vec(t_vec));
  // ********
  // Tasks and functions
  // ********
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  // One write; bready is raised only once bvalid is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  // One read; rready is raised only once rvalid is seen
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    chk("rresp", 32'(er), 32'(rresp));
    chk("rdata", e, rdata);
  endtask
  // Line command, mirrored into the expected state
  task automatic cmd(input int n, input vic_op_e op);
    wr(OFF_LINE_CMD, {22'h0, 2'(op), 3'h0, 5'(n)});
    case (op)
      VIC_OP_ENABLE: en_m[n] = 1'b1;
      VIC_OP_DISABLE: en_m[n] = 1'b0;
      VIC_OP_SET_PEND: pend_m[n] = 1'b1;
      default: pend_m[n] = 1'b0;
    endcase
  endtask
  // Wait for the core's next take and compare it
  task automatic take(input int e);
    repeat (200) if (takes === seen) @(posedge aclk);
    chk("takes", 32'(seen + 8'h01), 32'(takes));
    seen = takes;
    chk("line", 32'(e), 32'(t_line));
    chk("vector", vec_m[e], t_vec);
    pend_m[e] = 1'b0;
  endtask
  // Winner: lowest priority value, then lowest line
  function automatic int best(input logic [31:0] p);
    int b;
    b = -1;
    for (int i = 0; i < 32; i++) if (p[i] && (b < 0 || prio_m[i] < prio_m[b])) b = i;
    return b;
  endfunction
  // Verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ********
  // Watchdog and main sequence
  // ********
  initial begin
    #160000;
    fails++;
    conclude();
  end
  initial begin
    fails = 0; compares = 0; seed = 84; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf;
    irq_src = 32'h0; delay = 3'h0; seen = 8'h00; en_m = 32'h0; pend_m = 32'h0;
    for (int i = 0; i < 32; i++) prio_m[i] = PRIO_RST;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, unmapped and read-only places
    rd(OFF_CTRL, 32'h0); rd(OFF_PEND, 32'h0); rd(OFF_ACTIVE, 32'h0); rd(OFF_LINE_VEC, 32'h0);
    rd(OFF_LINE_STAT, {25'h0, PRIO_RST, 4'h0});
    rd(8'h30, 32'h0, RESP_SLVERR); rd(8'h02, 32'h0, RESP_SLVERR); wr(OFF_PEND, 32'h1, RESP_SLVERR);
    // Enable word: set merges ones, save read returns and clears
    m = $random(seed); wr(OFF_EN_SET, m); en_m = m; m = $random(seed); wr(OFF_EN_SET, m); en_m |= m;
    rd(OFF_EN_SET, en_m);
    rd(OFF_EN_SAVE, en_m); en_m = 32'h0; rd(OFF_EN_SET, en_m);
    // Every line command on random lines, global flag off
    for (int i = 0; i < 24; i++) begin
      l = $random(seed) & 31; cmd(l, vic_op_e'(i % 4)); wr(OFF_LINE_SEL, 32'(l));
      rd(OFF_EN_SET, en_m); rd(OFF_PEND, pend_m);
      rd(OFF_LINE_STAT, {25'h0, prio_m[l], 2'h0, pend_m[l], en_m[l]});
      chk("irq_req", 32'h0, 32'(irq_req));
    end
    // Priorities and vectors of all lines, then read back
    for (int i = 0; i < 32; i++) begin
      prio_m[i] = 3'($random(seed)); vec_m[i] = $random(seed); wr(OFF_LINE_SEL, 32'(i));
      wr(OFF_LINE_PRIO, 32'(prio_m[i])); wr(OFF_LINE_VEC, vec_m[i]);
    end
    for (int i = 0; i < 32; i++) begin
      wr(OFF_LINE_SEL, 32'(i)); rd(OFF_LINE_PRIO, 32'(prio_m[i]));
      rd(OFF_LINE_VEC, vec_m[i]);
    end
    // Exception vectors, a table of their own
    for (int i = 0; i < 16; i++) begin
      sv[i] = $random(seed); wr(OFF_SYS_SEL, 32'(i)); wr(OFF_SYS_VEC, sv[i]);
    end
    for (int i = 0; i < 16; i++) begin
      wr(OFF_SYS_SEL, 32'(i)); rd(OFF_SYS_VEC, sv[i]);
    end
    wr(OFF_LINE_SEL, 32'h0); rd(OFF_LINE_VEC, vec_m[0]);
    wstrb <= 4'h3; wr(OFF_LINE_VEC, 32'hffff_ffff); wstrb <= 4'hf; vec_m[0][15:0] = 16'hffff;
    rd(OFF_LINE_VEC, vec_m[0]);
    // Arbitration of hardware edges on a random enable set
    for (int i = 0; i < 32; i++) if (pend_m[i]) cmd(i, VIC_OP_CLR_PEND);
    rd(OFF_EN_SAVE, en_m); m = $random(seed); wr(OFF_EN_SET, m); en_m = m;
    m = $random(seed); irq_src <= m; @(posedge aclk); irq_src <= 32'h0; pend_m |= m;
    repeat (3) @(posedge aclk);
    chk("irq_req", 32'h0, 32'(irq_req));
    rd(OFF_PEND, pend_m);
    wr(OFF_CTRL, 32'h1);
    while ((pend_m & en_m) != 32'h0) begin
      delay <= 3'($random(seed));
      take(best(pend_m & en_m));
    end
    repeat (5) @(posedge aclk);
    chk("irq_req", 32'h0, 32'(irq_req));
    rd(OFF_PEND, pend_m);
    // Software set and clear, global flag blocking
    l = $random(seed) & 31; wr(OFF_CTRL, 32'h0);
    cmd(l, VIC_OP_DISABLE); cmd(l, VIC_OP_SET_PEND); cmd(l, VIC_OP_CLR_PEND); cmd(l, VIC_OP_ENABLE);
    wr(OFF_CTRL, 32'h1); repeat (4) @(posedge aclk);
    chk("irq_req", 32'h0, 32'(irq_req));
    wr(OFF_CTRL, 32'h0); cmd(l, VIC_OP_SET_PEND); repeat (4) @(posedge aclk);
    chk("irq_req", 32'h0, 32'(irq_req));
    rd(OFF_EN_SET, en_m);
    wr(OFF_CTRL, 32'h1);
    take(l);
    conclude();
  end
endmodule

// ==== dv/vic_core_model.sv ====
// Purpose: Processor core that takes vectored requests.
// Assumes: Shares aclk; acks with a one-cycle pulse.
// Notes: Waits delay cycles before each ack; counts takes.
`timescale 1ns/1ps
module vic_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request side
  input wire logic irq_req,
  input wire logic [vic_pkg::VIC_LINE_W-1:0] irq_line,
  input wire logic [vic_pkg::VIC_VEC_W-1:0] irq_vector,
  output logic irq_ack,
  // Pacing and record
  input wire logic [2:0] delay,
  output logic [7:0] takes,
  output logic [vic_pkg::VIC_LINE_W-1:0] taken_line,
  output logic [vic_pkg::VIC_VEC_W-1:0] taken_vec
);
  import vic_pkg::*;
  logic [2:0] cnt;  // Cycles the request has waited
  // Ack after the wait, record line and vector at the ack edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ack <= 1'b0;
      cnt <= 3'h0;
      takes <= 8'h00;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      if (irq_req) begin  // Handshake taken
        takes <= takes + 8'h01;
        taken_line <= irq_line;
        taken_vec <= irq_vector;
      end
    end else if (irq_req) begin
      if (cnt >= delay) begin
        irq_ack <= 1'b1;
        cnt <= 3'h0;
      end else begin
        cnt <= cnt + 3'h1;
      end
    end else begin
      cnt <= 3'h0;
    end
  end
endmodule

// ==== dv/vic_top_assertions.sv ====
// Purpose: Concurrent checks on the controller's bus and core ports.
// Assumes: One clock aclk, synchronous active-low aresetn.
// Notes: Bound into every vic_top instance, watches both inputs and outputs.
`timescale 1ns/1ps
module vic_top_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // Read channels
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [vic_pkg::VIC_DW-1:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Core handshake
  input wire logic irq_req,
  input wire logic irq_ack
);
  import vic_pkg::*;
  // ********
  // Clocking and sequences
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Core takes the shown request
  sequence s_ack;
    irq_req && irq_ack;
  endsequence
  // Address and data taken at one edge
  sequence s_wtake;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  // Response shows on the second edge
  sequence s_bwait;
    !s_axil_bvalid ##1 s_axil_bvalid;
  endsequence
  // ********
  // Properties
  // ********
  property p_ack_drop;
    s_ack |=> !irq_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request stayed after ack");
  property p_b_latency;
    s_wtake |=> s_bwait;
  endproperty
  a_b_latency: assert property (p_b_latency) else $error("write response late");
  property p_b_hold;
    s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_aw_block;
    s_axil_bvalid |-> !s_axil_awready && !s_axil_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during response");
  property p_r_latency;
    s_axil_arvalid && s_axil_arready |=> s_axil_rvalid;
  endproperty
  a_r_latency: assert property (p_r_latency) else $error("read data late");
  property p_r_hold;
    s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata) && $stable(s_axil_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_ar_block;
    s_axil_rvalid |-> !s_axil_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken during data");
  property p_bresp_code;
    s_axil_bvalid |-> s_axil_bresp == RESP_OKAY || s_axil_bresp == RESP_SLVERR;
  endproperty
  a_bresp_code: assert property (p_bresp_code) else $error("bad write response code");
  property p_err_zero;
    s_axil_rvalid && s_axil_rresp == RESP_SLVERR |-> s_axil_rdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read carries data");
endmodule
bind vic_top vic_top_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready), .s_axil_wvalid(s_axil_wvalid),
  .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid),
  .s_axil_bready(s_axil_bready), .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
  .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
  .s_axil_rready(s_axil_rready), .irq_req(irq_req), .irq_ack(irq_ack));

// ==== logic/vic_arbiter.sv ====
// Purpose: Picks the requesting line with the best priority.
// Assumes: Lower priority value wins; ties go to lower line number.
// Notes: Pure combinational scan.
`timescale 1ns/1ps
module vic_arbiter #(
  parameter int N = 32,
  parameter int PW = 3,
  parameter int LW = 5
) (
  // Arbitration carrier
  vic_arb_if.arb arb
);
  // ********
  // Scan
  // ********
  logic [PW-1:0] best_p;   // Best priority so far
  logic found;             // Some request seen
  logic [LW-1:0] best_l;   // Line of best priority

  // Strict compare keeps the lowest index on a tie
  always_comb begin
    best_p = '1;
    found = 1'b0;
    best_l = '0;
    for (int i = 0; i < N; i++) begin
      if (arb.req[i] && (!found || arb.prio[i*PW +: PW] < best_p)) begin
        found = 1'b1;
        best_p = arb.prio[i*PW +: PW];
        best_l = LW'(i);
      end
    end
  end

  assign arb.win_valid = found;
  assign arb.win_line = best_l;
endmodule

// ==== logic/vic_top.sv ====
// Purpose: Vectored interrupt controller with an AXI4-Lite register port.
// Assumes: Interrupt sources and core handshake share aclk.
// Notes: Source rising edges latch pending; the core acks the shown line.
`timescale 1ns/1ps
//
// Contract
// - Global enable flag gates all requests.
// - Thirty-two lines, each addressed by number.
// - Enable set readable as one word.
// - Enable-set write turns on one bits.
// - Single line enable set or cleared.
// - Line enable reads back as one/zero.
// - Each line holds a readable vector.
// - Sixteen separate system exception vectors.
// - Three-bit priority, zero is highest.
// - Software can force a line pending.
// - Software can clear a pending line.
module vic_top #(
  parameter int LINES = vic_pkg::VIC_LINES,
  parameter int SYS = vic_pkg::VIC_SYS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [vic_pkg::VIC_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  // AXI4-Lite write data
  input wire logic [vic_pkg::VIC_DW-1:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // AXI4-Lite read address
  input wire logic [vic_pkg::VIC_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  // AXI4-Lite read data
  output logic [vic_pkg::VIC_DW-1:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Peripheral interrupt sources
  input wire logic [LINES-1:0] irq_src,
  // Core request and acknowledge
  output logic irq_req,
  output logic [vic_pkg::VIC_LINE_W-1:0] irq_line,
  output logic [vic_pkg::VIC_VEC_W-1:0] irq_vector,
  input wire logic irq_ack
);
  import vic_pkg::*;

  // ********
  // State
  // ********
  logic global_irq_enable_flag;              // Global mask
  logic [LINES-1:0] line_enable_bits;        // Per-line enables
  logic [LINES-1:0] pend;                    // Per-line pending flags
  logic [LINES-1:0] next_pend;               // Pending after this cycle
  logic [LINES-1:0] src_q;                   // Source level last cycle
  logic [VIC_PRIO_W-1:0] prio [LINES];       // Per-line priority
  logic [VIC_VEC_W-1:0] vec [LINES];         // Per-line vector
  logic [VIC_VEC_W-1:0] sys_vec [SYS];       // System exception vectors
  logic [VIC_LINE_W-1:0] line_sel;           // Line for indexed access
  logic [VIC_SYS_W-1:0] sys_sel;             // Exception for indexed access

  // ********
  // Bus slave signals
  // ********
  logic [VIC_AW-1:0] aw_addr;                // Held write address
  logic [VIC_DW-1:0] w_data;                 // Held write data
  logic [3:0] w_strb;                        // Held byte strobes
  logic wr_go;                               // Both halves held, do write
  logic rd_go;                               // Read address taken
  logic wr_ok;                               // Write address is mapped and writable
  logic rd_ok;                               // Read address is mapped
  logic [VIC_DW-1:0] rd_val;                 // Read mux result
  logic [VIC_DW-1:0] strb_mask;              // Byte lanes as bit mask
  logic cmd_go;                              // Line command written
  logic [VIC_LINE_W-1:0] cmd_line;           // Commanded line
  vic_op_e cmd_op;                           // Commanded operation
  logic ack_go;                              // Core takes the request

  // Byte enables merge into a stored word
  function automatic logic [VIC_DW-1:0] merge(input logic [VIC_DW-1:0] old,
                                               input logic [VIC_DW-1:0] nw,
                                               input logic [VIC_DW-1:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // ********
  // Write channel
  // ********
  // Address and data are taken independently, then held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_awready <= 1'b1;
      aw_addr <= '0;
    end else if (s_axil_awvalid && s_axil_awready) begin
      s_axil_awready <= 1'b0;
      aw_addr <= s_axil_awaddr;
    end else if (s_axil_bvalid && s_axil_bready) begin
      s_axil_awready <= 1'b1;
    end
  end

  // Data half of the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_wready <= 1'b1;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axil_wvalid && s_axil_wready) begin
      s_axil_wready <= 1'b0;
      w_data <= s_axil_wdata;
      w_strb <= s_axil_wstrb;
    end else if (s_axil_bvalid && s_axil_bready) begin
      s_axil_wready <= 1'b1;
    end
  end

  assign wr_go = !s_axil_awready && !s_axil_wready && !s_axil_bvalid;

  // Write decode
  always_comb begin
    case (aw_addr)
      OFF_CTRL, OFF_EN_SET, OFF_EN_SAVE, OFF_LINE_CMD, OFF_LINE_SEL,
      OFF_LINE_PRIO, OFF_LINE_VEC, OFF_SYS_SEL, OFF_SYS_VEC: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Strobes widened to a bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      strb_mask[b*8 +: 8] = {8{w_strb[b]}};
    end
  end

  // Response follows the write by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axil_bready) begin
      s_axil_bvalid <= 1'b0;
    end
  end

  // ********
  // Read channel
  // ********
  assign rd_go = s_axil_arvalid && s_axil_arready;

  // Read mux on the incoming address
  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    case (s_axil_araddr)
      OFF_CTRL: rd_val[CTRL_GIE_BIT] = global_irq_enable_flag;
      OFF_EN_SET, OFF_EN_SAVE: rd_val = line_enable_bits;
      OFF_LINE_CMD: rd_val = '0;
      OFF_LINE_SEL: rd_val[VIC_LINE_W-1:0] = line_sel;
      OFF_LINE_STAT: begin
        rd_val[STAT_EN_BIT] = line_enable_bits[line_sel];
        rd_val[STAT_PEND_BIT] = pend[line_sel];
        rd_val[STAT_PRIO_LSB +: VIC_PRIO_W] = prio[line_sel];
      end
      OFF_LINE_PRIO: rd_val[VIC_PRIO_W-1:0] = prio[line_sel];
      OFF_LINE_VEC: rd_val = vec[line_sel];
      OFF_SYS_SEL: rd_val[VIC_SYS_W-1:0] = sys_sel;
      OFF_SYS_VEC: rd_val = sys_vec[sys_sel];
      OFF_PEND: rd_val = pend;
      OFF_ACTIVE: begin
        rd_val[ACT_VALID_BIT] = irq_req;
        rd_val[VIC_LINE_W-1:0] = irq_line;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Data registered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= '0;
      s_axil_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= rd_val;
      s_axil_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axil_rvalid && s_axil_rready) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid <= 1'b0;
    end
  end

  // ********
  // Control registers
  // ********
  // Global mask; line enables are left as they are
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_irq_enable_flag <= GIE_RST;
    end else if (wr_go && aw_addr == OFF_CTRL && w_strb[0]) begin
      global_irq_enable_flag <= w_data[CTRL_GIE_BIT];
    end
  end

  // Indexed selectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_sel <= '0;
      sys_sel <= '0;
    end else if (wr_go && w_strb[0]) begin
      if (aw_addr == OFF_LINE_SEL) begin
        line_sel <= w_data[VIC_LINE_W-1:0];
      end
      if (aw_addr == OFF_SYS_SEL) begin
        sys_sel <= w_data[VIC_SYS_W-1:0];
      end
    end
  end

  // Line command fields
  assign cmd_go = wr_go && aw_addr == OFF_LINE_CMD && w_strb[0] && w_strb[1];
  assign cmd_line = w_data[CMD_LINE_LSB +: VIC_LINE_W];
  assign cmd_op = vic_op_e'(w_data[CMD_OP_LSB +: 2]);

  // Enables: save-read clears all, set word ORs, commands hit one line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_enable_bits <= EN_RST;
    end else begin
      if (rd_go && s_axil_araddr == OFF_EN_SAVE) begin
        line_enable_bits <= '0;
      end
      if (wr_go && aw_addr == OFF_EN_SET) begin
        line_enable_bits <= line_enable_bits | (w_data & strb_mask);
      end
      if (cmd_go) begin
        case (cmd_op)
          VIC_OP_ENABLE: line_enable_bits[cmd_line] <= 1'b1;
          VIC_OP_DISABLE: line_enable_bits[cmd_line] <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // Priorities, stored per line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < LINES; i++) begin
        prio[i] <= PRIO_RST;
      end
    end else if (wr_go && aw_addr == OFF_LINE_PRIO && w_strb[0]) begin
      prio[line_sel] <= w_data[VIC_PRIO_W-1:0];
    end
  end

  // Line vectors and system exception vectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < LINES; i++) begin
        vec[i] <= VEC_RST;
      end
      for (int j = 0; j < SYS; j++) begin
        sys_vec[j] <= VEC_RST;
      end
    end else if (wr_go) begin
      if (aw_addr == OFF_LINE_VEC) begin
        vec[line_sel] <= merge(vec[line_sel], w_data, strb_mask);
      end
      if (aw_addr == OFF_SYS_VEC) begin
        sys_vec[sys_sel] <= merge(sys_vec[sys_sel], w_data, strb_mask);
      end
    end
  end

  // ********
  // Pending flags
  // ********
  assign ack_go = irq_req && irq_ack;

  // Clears first, sets last, so a set in the same cycle wins
  always_comb begin
    next_pend = pend;
    if (cmd_go && cmd_op == VIC_OP_CLR_PEND) begin
      next_pend[cmd_line] = 1'b0;
    end
    if (ack_go) begin
      next_pend[irq_line] = 1'b0;
    end
    next_pend = next_pend | (irq_src & ~src_q);
    if (cmd_go && cmd_op == VIC_OP_SET_PEND) begin
      next_pend[cmd_line] = 1'b1;
    end
  end

  // Source edge history and pending state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= '0;
      pend <= '0;
    end else begin
      src_q <= irq_src;
      pend <= next_pend;
    end
  end

  // ********
  // Arbitration and core handshake
  // ********
  vic_arb_if #(.N(LINES), .PW(VIC_PRIO_W), .LW(VIC_LINE_W)) arb_bus ();

  assign arb_bus.req = global_irq_enable_flag ? (pend & line_enable_bits) : '0;
  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      arb_bus.prio[i*VIC_PRIO_W +: VIC_PRIO_W] = prio[i];
    end
  end

  vic_arbiter #(.N(LINES), .PW(VIC_PRIO_W), .LW(VIC_LINE_W)) u_arb (
    .arb(arb_bus)
  );

  // Winner shown with its vector; ack drops the request one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= 1'b0;
      irq_line <= '0;
      irq_vector <= '0;
    end else if (ack_go) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= arb_bus.win_valid;
      irq_line <= arb_bus.win_line;
      irq_vector <= vec[arb_bus.win_line];
    end
  end
endmodule
